// ### hpc_top.sv
// Purpose: hibernation power controller with rtc, tamper and memory
// Assumes: apb slave, clock enable freezes all state
// Notes: pins pass four flops, a change counts when two agree
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module hpc_top #(
  parameter int MEM_WORDS = 16,
  parameter int TAMP_IOS = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire hpc_pkg::hpc_pins_t pins,
  input wire logic [TAMP_IOS-1:0] tamper_io,
  output logic processor_power_on,
  output logic tamper_event,
  output logic hib_irq
);
  import hpc_pkg::*;

  if (MEM_WORDS < 1 || MEM_WORDS > 16) begin : g_bad_mem
    $error("MEM_WORDS 1..16");
  end
  if (TAMP_IOS < 1 || TAMP_IOS > 8) begin : g_bad_tamp
    $error("TAMP_IOS 1..8");
  end

  // ==========================================================
  // pin synchronisers
  localparam int PW = 5 + TAMP_IOS;
  logic [PW-1:0] s1, s2, s3, pin_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      pin_q <= '0;
    end else if (clk_en) begin
      s1 <= {tamper_io, pins};
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < PW; i++) begin
        if (s2[i] == s3[i]) begin
          pin_q[i] <= s3[i];
        end
      end
    end
  end
  logic p_wake, p_gpio, p_rst, p_lowbat, p_oscfail;
  logic [TAMP_IOS-1:0] p_tamp;
  assign {p_tamp, p_wake, p_gpio, p_rst, p_lowbat, p_oscfail} = pin_q;

  // ==========================================================
  // apb decode
  logic wr, rd;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  logic mem_hit;
  logic [3:0] mem_idx;
  assign mem_hit = paddr >= OFS_MEM &&
                   paddr < OFS_MEM + 12'(MEM_WORDS * 4);
  assign mem_idx = 4'(paddr[5:2]);
  logic known;
  always_comb begin
    unique case (paddr)
      OFS_CTRL, OFS_RTC, OFS_MATCH, OFS_SSMATCH, OFS_TRIM, OFS_SUBSEC,
      OFS_IM, OFS_RIS, OFS_MIS, OFS_IC, OFS_TAMPCTL, OFS_TAMPSTAT,
      OFS_TAMPLOG: known = 1'b1;
      default: known = mem_hit;
    endcase
  end

  // ==========================================================
  // control register
  logic [12:0] ctrl;
  logic enabled, rtc_run;
  assign enabled = ctrl[CTL_ENABLE];
  assign rtc_run = ctrl[CTL_RTC_RUN];
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl <= '0;
    end else if (clk_en) begin
      if (wr && paddr == OFS_CTRL) begin
        ctrl <= pwdata[12:0];
        ctrl[CTL_HIB_REQ] <= 1'b0;
        ctrl[CTL_BAT_CHECK] <= 1'b0;
      end
    end
  end
  logic ctl_wr;
  assign ctl_wr = wr && paddr == OFS_CTRL && enabled;
  logic hib_req_w, bat_force_w, osc_rec_w;
  assign hib_req_w = ctl_wr && pwdata[CTL_HIB_REQ];
  assign bat_force_w = ctl_wr && pwdata[CTL_BAT_CHECK];
  assign osc_rec_w = ctl_wr && pwdata[CTL_OSC_RECOVER];

  // ==========================================================
  // rtc seconds, subseconds, trim
  logic [31:0] rtc_sec, rtc_match;
  logic [14:0] subsec, ss_match;
  logic [15:0] trim;
  logic rtc_hit;
  assign rtc_hit = enabled && rtc_run && rtc_sec == rtc_match &&
                   subsec == ss_match;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rtc_sec <= '0;
      subsec <= '0;
    end else if (clk_en) begin
      if (wr && paddr == OFS_RTC) begin
        rtc_sec <= pwdata;
        subsec <= '0;
      end else if (enabled && rtc_run) begin
        // trim sets the last subsecond of each second
        if (subsec >= SUBSEC_MAX ||
            (subsec == trim[14:0] && trim != TRIM_RESET)) begin
          subsec <= '0;
          rtc_sec <= rtc_sec + 32'h0000_0001;
        end else begin
          subsec <= subsec + 15'h0001;
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rtc_match <= '1;
      ss_match <= '0;
      trim <= TRIM_RESET;
    end else if (clk_en && wr) begin
      if (paddr == OFS_MATCH) rtc_match <= pwdata;
      if (paddr == OFS_SSMATCH) ss_match <= pwdata[14:0];
      if (paddr == OFS_TRIM) trim <= pwdata[15:0];
    end
  end

  // ==========================================================
  // battery check
  logic [7:0] bat_cnt;
  logic bat_busy, low_battery_flag;
  assign bat_busy = bat_cnt != 8'h00;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bat_cnt <= '0;
      low_battery_flag <= 1'b0;
    end else if (clk_en) begin
      if (bat_force_w && !bat_busy) begin
        bat_cnt <= 8'(BAT_CHECK_CYC);
      end else if (bat_busy) begin
        bat_cnt <= bat_cnt - 8'h01;
        if (bat_cnt == 8'h01) low_battery_flag <= p_lowbat;
      end
    end
  end

  // ==========================================================
  // tamper
  logic [15:0] tctl;
  logic [TAMP_IOS-1:0] tamp_prev;
  logic osc_valid, tamp_hit, tamp_gpio, tamp_osc;
  logic [31:0] tamp_log;
  logic [1:0] tamp_stat;
  assign tamp_gpio = |((p_tamp ^ tamp_prev) &
                       tctl[TMP_GPIO_LSB +: TAMP_IOS]);
  assign tamp_osc = tctl[TMP_OSC_SEL] && p_oscfail && osc_valid;
  assign tamp_hit = enabled && tctl[TMP_EN] &&
                    (tamp_gpio || tamp_osc);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tctl <= '0;
      tamp_prev <= '0;
      osc_valid <= 1'b1;
      tamper_event <= 1'b0;
    end else if (clk_en) begin
      if (wr && paddr == OFS_TAMPCTL) tctl <= pwdata[15:0];
      tamp_prev <= p_tamp;
      tamper_event <= tamp_hit;
      if (tamp_osc) osc_valid <= 1'b0;
      else if (osc_rec_w && !p_oscfail) osc_valid <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tamp_log <= '0;
      tamp_stat <= '0;
    end else if (clk_en) begin
      if (tamp_hit) begin
        tamp_log <= rtc_sec;
        tamp_stat <= {tamp_osc, tamp_gpio};
      end else if (wr && paddr == OFS_TAMPSTAT) begin
        tamp_stat <= '0;
      end
    end
  end

  // ==========================================================
  // battery-backed memory
  logic [31:0] mem [MEM_WORDS];
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < MEM_WORDS; i++) mem[i] <= '0;
    end else if (clk_en) begin
      if (wr && mem_hit) mem[mem_idx] <= pwdata;
      for (int i = 0; i < MEM_WORDS; i++) begin
        if (tamp_hit && (tctl[TMP_ERASE_ALL] ||
            (tctl[TMP_ERASE_HALF] && i >= MEM_WORDS / 2))) begin
          mem[i] <= '0;
        end
      end
    end
  end

  // ==========================================================
  // interrupts, set wins over clear
  hpc_state_t state_q;
  logic [INT_W-1:0] ris, im, int_set;
  assign int_set = {rtc_hit, bat_busy && bat_cnt == 8'h01 && p_lowbat,
                    state_q == HPC_HIBERNATE && p_wake, wr};
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ris <= '0;
      im <= '0;
      hib_irq <= 1'b0;
    end else if (clk_en) begin
      if (wr && paddr == OFS_IM) im <= pwdata[INT_W-1:0];
      ris <= (ris & ~((wr && paddr == OFS_IC) ? pwdata[INT_W-1:0] : '0))
             | int_set;
      hib_irq <= |(ris & im);
    end
  end

  // ==========================================================
  // power sequencer
  logic [2:0] pd_cnt;
  logic wake_now, powered_once;
  assign wake_now = (ctrl[CTL_WAKE_PIN] && p_wake) ||
                    (ctrl[CTL_WAKE_RTC] && rtc_hit) ||
                    (ctrl[CTL_WAKE_BAT] && p_lowbat) ||
                    (ctrl[CTL_WAKE_GPIO] && p_gpio) ||
                    (ctrl[CTL_WAKE_RST] && p_rst) ||
                    (tamp_hit && tctl[TMP_WAKE]);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= HPC_ON;
      pd_cnt <= '0;
      processor_power_on <= 1'b1;
      powered_once <= 1'b0;
    end else if (clk_en) begin
      if (enabled) powered_once <= 1'b1;
      unique case (state_q)
        HPC_ON: begin
          if (hib_req_w) begin
            state_q <= bat_busy ? HPC_WAIT_BAT : HPC_POWER_DOWN;
            pd_cnt <= 3'(POWER_DOWN_CYC);
          end
        end
        HPC_WAIT_BAT: begin
          if (!bat_busy) begin
            state_q <= (ctrl[CTL_BAT_ABORT] && low_battery_flag) ?
                       HPC_ON : HPC_POWER_DOWN;
          end
        end
        HPC_POWER_DOWN: begin
          if (ctrl[CTL_BAT_ABORT] && p_lowbat) begin
            state_q <= HPC_ON;
          end else if (pd_cnt == 3'h0) begin
            state_q <= HPC_HIBERNATE;
            processor_power_on <= 1'b0;
          end else begin
            pd_cnt <= pd_cnt - 3'h1;
          end
        end
        HPC_HIBERNATE: begin
          if (wake_now) begin
            state_q <= HPC_ON;
            processor_power_on <= 1'b1;
          end
        end
        default: state_q <= HPC_ON;
      endcase
    end
  end

  // ==========================================================
  // read mux and apb answer
  logic [31:0] rdata;
  always_comb begin
    rdata = '0;
    if (mem_hit) rdata = mem[mem_idx];
    unique case (paddr)
      OFS_CTRL: rdata = {15'h0000, powered_once, 1'b0, osc_valid,
                         powered_once, 3'h0, bat_busy, ctrl[8:0]};
      OFS_RTC: rdata = rtc_sec;
      OFS_MATCH: rdata = rtc_match;
      OFS_SSMATCH: rdata = {17'h0_0000, ss_match};
      OFS_TRIM: rdata = {16'h0000, trim};
      OFS_SUBSEC: rdata = {17'h0_0000, subsec};
      OFS_IM: rdata = {28'h000_0000, im};
      OFS_RIS: rdata = {28'h000_0000, ris};
      OFS_MIS: rdata = {28'h000_0000, ris & im};
      OFS_TAMPCTL: rdata = {16'h0000, tctl};
      OFS_TAMPSTAT: rdata = {29'h0000_0000, tctl[TMP_EN], tamp_stat};
      OFS_TAMPLOG: rdata = tamp_log;
      default: ;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known;
      if (psel && !penable && !pwrite) prdata <= rdata;
    end
  end

  // ==========================================================
  // checks
  a_rtc_frozen: assert property (
    @(posedge clk) disable iff (!reset_n)
    !rtc_run && !(wr && paddr == OFS_RTC) |=> $stable(rtc_sec))
    else $error("rtc moved while stopped");
  a_tamper_pulse: assert property (
    @(posedge clk) disable iff (!reset_n)
    tamp_hit && clk_en |=> tamper_event)
    else $error("tamper seen without event pulse");
  a_check_start: assert property (
    @(posedge clk) disable iff (!reset_n)
    bat_force_w && !bat_busy && clk_en |=> bat_busy)
    else $error("forced check did not start");
  a_hold_for_check: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_q == HPC_WAIT_BAT |-> processor_power_on)
    else $error("power removed during battery check");
  a_off_in_hib: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_q == HPC_HIBERNATE |-> !processor_power_on)
    else $error("processor powered in hibernation");
  a_masked_irq: assert property (
    @(posedge clk) disable iff (!reset_n)
    clk_en |=> hib_irq == $past(|(ris & im)))
    else $error("irq does not follow masked status");
  c_enter_hib: cover property (
    @(posedge clk) disable iff (!reset_n) state_q == HPC_HIBERNATE);
  c_tamper_seen: cover property (
    @(posedge clk) disable iff (!reset_n) tamper_event);
  c_check_done: cover property (
    @(posedge clk) disable iff (!reset_n) bat_cnt == 8'h01);
endmodule
`default_nettype wire

// ### hpc_pkg.sv
// Purpose: constants and types for the hibernation power controller
// Assumes: apb register bus, 32-bit words, 10 MHz clock
// Notes: offsets are byte addresses
package hpc_pkg;
  // ==========================================================
  // register offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_RTC = 12'h004;
  localparam logic [11:0] OFS_MATCH = 12'h008;
  localparam logic [11:0] OFS_SSMATCH = 12'h00C;
  localparam logic [11:0] OFS_TRIM = 12'h010;
  localparam logic [11:0] OFS_SUBSEC = 12'h014;
  localparam logic [11:0] OFS_IM = 12'h018;
  localparam logic [11:0] OFS_RIS = 12'h01C;
  localparam logic [11:0] OFS_MIS = 12'h020;
  localparam logic [11:0] OFS_IC = 12'h024;
  localparam logic [11:0] OFS_TAMPCTL = 12'h028;
  localparam logic [11:0] OFS_TAMPSTAT = 12'h02C;
  localparam logic [11:0] OFS_TAMPLOG = 12'h030;
  localparam logic [11:0] OFS_MEM = 12'h040;
  // ==========================================================
  // control register bit positions
  localparam int CTL_ENABLE = 0;
  localparam int CTL_RTC_RUN = 1;
  localparam int CTL_HIB_REQ = 2;
  localparam int CTL_WAKE_PIN = 3;
  localparam int CTL_WAKE_RTC = 4;
  localparam int CTL_WAKE_BAT = 5;
  localparam int CTL_WAKE_GPIO = 6;
  localparam int CTL_WAKE_RST = 7;
  localparam int CTL_BAT_ABORT = 8;
  localparam int CTL_BAT_CHECK = 9;
  localparam int CTL_OSC_PD = 10;
  localparam int CTL_DRV_STRONG = 11;
  localparam int CTL_DRV_WEAK = 12;
  localparam int CTL_ACTIVE = 13;
  localparam int CTL_OSC_VALID = 14;
  localparam int CTL_OSC_RECOVER = 15;
  localparam int CTL_POWERED = 16;
  // ==========================================================
  // interrupt bits
  localparam int INT_WR = 0;
  localparam int INT_PIN = 1;
  localparam int INT_LOWBAT = 2;
  localparam int INT_RTC0 = 3;
  localparam int INT_W = 4;
  // tamper control fields
  localparam int TMP_EN = 0;
  localparam int TMP_ERASE_ALL = 1;
  localparam int TMP_ERASE_HALF = 2;
  localparam int TMP_WAKE = 3;
  localparam int TMP_OSC_SEL = 4;
  localparam int TMP_GPIO_LSB = 8;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int BAT_CHECK_NS = 1_000;
  localparam int BAT_CHECK_CYC = (BAT_CHECK_NS * (CLK_HZ / 1_000_000)
                                  + 999) / 1_000;
  localparam int POWER_DOWN_CYC = 4;
  localparam logic [14:0] SUBSEC_MAX = 15'h7FFF;
  localparam logic [15:0] TRIM_RESET = 16'h7FFF;

  typedef enum logic [3:0] {
    HPC_ON = 4'b0001,
    HPC_WAIT_BAT = 4'b0010,
    HPC_POWER_DOWN = 4'b0100,
    HPC_HIBERNATE = 4'b1000
  } hpc_state_t;

  typedef struct packed {
    logic wake_pin;
    logic gpio_wake;
    logic reset_pin;
    logic low_battery;
    logic osc_fail;
  } hpc_pins_t;
endpackage

// ### hpc_top_tb.sv
// Purpose: self-checking bench for the hibernation power controller
// Assumes: apb slave answers within a few cycles, pins synchronised inside
// Notes: all registers reached through the apb task only
`timescale 1ns/10ps
`default_nettype none
module hpc_top_tb;
  import hpc_pkg::*;
  logic clk, reset_n, clk_en, psel, penable, pwrite, err, hit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, cb;
  logic pready, pslverr, processor_power_on, tamper_event, hib_irq;
  hpc_pins_t pins;
  logic [3:0] tamper_io;
  logic [11:0] regs [3] = '{OFS_MATCH, OFS_SSMATCH, OFS_TRIM};
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;

  hpc_top #(.MEM_WORDS(16), .TAMP_IOS(4)) uut (
    .clk(clk), .reset_n(reset_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .tamper_io(tamper_io), .processor_power_on(processor_power_on),
    .tamper_event(tamper_event), .hib_irq(hib_irq)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // closing and watchdog
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ==========================================================
  // apb master and compares
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fail_count++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    cmp(rd & m, exp);
  endtask

  task automatic wait_pw(input logic v);
    n = 0;
    while (processor_power_on !== v && n < 60) begin
      @(posedge clk);
      n++;
    end
    cmp({31'h0, processor_power_on}, {31'h0, v});
  endtask

  task automatic watch;
    hit = 1'b0;
    repeat (12) begin
      @(posedge clk);
      if (tamper_event === 1'b1) begin
        hit = 1'b1;
      end
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    clk_en = 1'b1;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pins = '0;
    tamper_io = 4'h0;
    cb = 32'h0000_0009;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b1, OFS_CTRL, cb);
    repeat (4) @(posedge clk);
    chk(OFS_CTRL, 32'h0000_4000, 32'h0000_4000);
    apb(1'b1, OFS_MEM, 32'hA5A5_0001);
    apb(1'b1, OFS_MEM + 12'h03C, 32'h5A5A_000F);
    chk(OFS_MEM, 32'hFFFF_FFFF, 32'hA5A5_0001);
    chk(OFS_MEM + 12'h03C, 32'hFFFF_FFFF, 32'h5A5A_000F);
    chk(12'h080, 32'hFFFF_FFFF, 32'h0000_0000);
    cmp({31'h0, err}, 32'h0000_0001);
    foreach (regs[i]) begin
      apb(1'b1, regs[i], 32'h0000_1234);
      chk(regs[i], 32'h0000_7FFF, 32'h0000_1234);
    end
    apb(1'b1, OFS_TRIM, {16'h0000, TRIM_RESET});
    // stopped counter keeps its loaded value
    apb(1'b1, OFS_RTC, 32'h0000_0005);
    repeat (20) @(posedge clk);
    chk(OFS_RTC, 32'hFFFF_FFFF, 32'h0000_0005);
    apb(1'b1, OFS_MATCH, 32'h0000_0005);
    apb(1'b1, OFS_SSMATCH, 32'h0000_0010);
    apb(1'b1, OFS_CTRL, cb | 32'h0000_0002);
    repeat (40) @(posedge clk);
    apb(1'b1, OFS_CTRL, cb);
    chk(OFS_RIS, 32'h0000_0008, 32'h0000_0008);
    apb(1'b1, OFS_IC, 32'h0000_0008);
    chk(OFS_RIS, 32'h0000_0008, 32'h0000_0000);
    apb(1'b1, OFS_IM, 32'h0000_0000);
    chk(OFS_MIS, 32'h0000_000F, 32'h0000_0000);
    cmp({31'h0, hib_irq}, 32'h0000_0000);
    apb(1'b1, OFS_IM, 32'h0000_0001);
    chk(OFS_MIS, 32'h0000_000F, 32'h0000_0001);
    cmp({31'h0, hib_irq}, 32'h0000_0001);
    apb(1'b1, OFS_IM, 32'h0000_0000);
    // forced battery check with a low cell, busy reads at bit 9
    pins.low_battery <= 1'b1;
    apb(1'b1, OFS_CTRL, cb | 32'h0000_0200);
    chk(OFS_CTRL, 32'h0000_0200, 32'h0000_0200);
    n = 0;
    do begin
      apb(1'b0, OFS_CTRL, 32'h0000_0000);
      n++;
    end while (rd[9] !== 1'b0 && n < 40);
    cmp(rd & 32'h0000_0200, 32'h0000_0000);
    chk(OFS_RIS, 32'h0000_0004, 32'h0000_0004);
    apb(1'b1, OFS_IC, 32'h0000_0004);
    chk(OFS_RIS, 32'h0000_0004, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, cb | 32'h0000_0104);
    repeat (30) @(posedge clk);
    cmp({31'h0, processor_power_on}, 32'h0000_0001);
    // request during a check must wait for it
    pins.low_battery <= 1'b0;
    apb(1'b1, OFS_CTRL, cb | 32'h0000_0200);
    apb(1'b1, OFS_CTRL, cb | 32'h0000_0004);
    chk(OFS_CTRL, 32'h0000_0200, 32'h0000_0200);
    cmp({31'h0, processor_power_on}, 32'h0000_0001);
    wait_pw(1'b0);
    pins.wake_pin <= 1'b1;
    wait_pw(1'b1);
    pins.wake_pin <= 1'b0;
    chk(OFS_RIS, 32'h0000_0002, 32'h0000_0002);
    chk(OFS_CTRL, 32'h0000_2000, 32'h0000_2000);
    // tamper ignored while disabled, then caught
    apb(1'b1, OFS_TAMPCTL, 32'h0000_0100);
    tamper_io[0] <= 1'b1;
    watch();
    cmp({31'h0, hit}, 32'h0000_0000);
    apb(1'b1, OFS_TAMPCTL, 32'h0000_0103);
    tamper_io[0] <= 1'b0;
    watch();
    cmp({31'h0, hit}, 32'h0000_0001);
    apb(1'b0, OFS_TAMPSTAT, 32'h0000_0000);
    cmp({31'h0, |rd}, 32'h0000_0001);
    chk(OFS_TAMPLOG, 32'hFFFF_FFFF, 32'h0000_0005);
    chk(OFS_MEM, 32'hFFFF_FFFF, 32'h0000_0000);
    apb(1'b1, OFS_TAMPSTAT, 32'hFFFF_FFFF);
    chk(OFS_TAMPSTAT, 32'h0000_0003, 32'h0000_0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
